/* File: ddrsp_pkg.sv */
// Functional notes
// - A valid write captures the data bus at the rising edges of both input clocks.
// - A read drives valid data on the data bus at the rising edges of both input clocks.
// - Without a selected read the data outputs float on their own, with no enable input; here dq_out is driven to zero and dq_oe_out goes low.
// - The by-18 part has two arrays of 1 M x 18 bits, the by-36 part two of 512 K x 36 bits.
// - The controller pulls the load strobe low to open a bus cycle, latched on the positive clock.
// - Every read or write moves exactly two words, one per clock edge, for one loaded address.
// - Active-low byte selects are taken on both clock edges; unselected bytes stay unchanged.
// - The shared address pins are sampled on the positive clock edge for both reads and writes.
// - With the load strobe low, direction high means read and direction low means write.
// - The output-valid flag is high while read data is valid and moves with the echo clocks.
// - The range pin is taken at power-up: low picks the low range, high or floating the high.
// - Every access starts on the positive input clock rise, which captures the inputs.
// - The negative input clock captures the second write word and launches read data.
// - A complementary pair of free-running echo clocks follows the positive input clock.
// - With the PLL-bypass input high, read data follows the load by two and a half cycles.
// - With the PLL-bypass input low, read latency is one clock cycle, for clocks up to 167 MHz.
package ddrsp_pkg;
  localparam int ADDR_W = 20;
  localparam int WORD_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BURST_WORDS = 2;
  // Read latency counted in half cycles of the input clock
  localparam int LAT_HALF_PLL = 5;
  localparam int LAT_HALF_BYPASS = 2;
  localparam int PIPE_DEPTH = 6;
  localparam int BYPASS_MAX_MHZ = 167;
  localparam logic [1:0] TERM_SETTLE = 2'h3;
  localparam logic TERM_HIGH_RESET = 1'b1;

  typedef struct packed {
    logic                    k;
    logic                    k_n;
    logic                    load_strobe_n;
    logic                    read_not_write;
    logic [ADDR_W-1:0]       addr;
    logic [LANES-1:0]        byte_lane_write_n;
    logic [WORD_W-1:0]       dq;
    logic                    pll_bypass_n;
    logic                    termination_range_select;
  } ddrsp_pins_t;

  typedef struct packed {
    logic              vld;
    logic              word_sel;
    logic [ADDR_W-1:0] addr;
  } ddrsp_pipe_t;
endpackage : ddrsp_pkg

/* File: ddrsp_bank.sv */
`timescale 1ns/100ps
module ddrsp_bank (
  input  wire logic                            clk_in,
  input  wire logic                            wr_en_in,
  input  wire logic [ddrsp_pkg::ADDR_W-1:0]    wr_addr_in,
  input  wire logic [ddrsp_pkg::WORD_W-1:0]    wr_data_in,
  input  wire logic [ddrsp_pkg::LANES-1:0]     lane_en_in,
  input  wire logic [ddrsp_pkg::ADDR_W-1:0]    rd_addr_in,
  output logic      [ddrsp_pkg::WORD_W-1:0]    rd_data_out
);
  import ddrsp_pkg::*;

  logic [WORD_W-1:0] mem [0:DEPTH-1];

  // Each lane written only when its select is active
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < LANES; i++) begin
      if (wr_en_in && lane_en_in[i]) begin
        mem[wr_addr_in][i*LANE_W +: LANE_W] <= wr_data_in[i*LANE_W +: LANE_W];
      end
    end
  end

  assign rd_data_out = mem[rd_addr_in];
endmodule : ddrsp_bank

/* File: ddrsp_port.sv */
`timescale 1ns/100ps
module ddrsp_port (
  input  wire logic                          sys_clk_in,
  input  wire logic                          reset_n_in,
  input  wire logic                          k_clk_in,
  input  wire logic                          k_clk_n_in,
  input  wire logic                          load_strobe_n_in,
  input  wire logic                          read_not_write_in,
  input  wire logic [ddrsp_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [ddrsp_pkg::LANES-1:0]   byte_lane_write_n_in,
  input  wire logic [ddrsp_pkg::WORD_W-1:0]  dq_in,
  input  wire logic                          pll_bypass_n_in,
  input  wire logic                          termination_range_select_in,
  output logic      [ddrsp_pkg::WORD_W-1:0]  dq_out,
  output logic                               dq_oe_out,
  output logic                               output_valid_flag_out,
  output logic                               echo_ref_out,
  output logic                               echo_ref_n_out,
  output logic                               termination_high_range_out
);
  import ddrsp_pkg::*;

  typedef struct packed {
    ddrsp_pins_t                   meta;
    ddrsp_pins_t                   sync;
    logic                          k_d;
    logic                          k_n_d;
    logic                          wr_pend;
    logic [ADDR_W-1:0]             wr_addr;
    ddrsp_pipe_t [PIPE_DEPTH-1:0]  pipe;
    logic [WORD_W-1:0]             dq;
    logic                          dq_oe;
    logic                          valid;
    logic                          echo;
    logic                          echo_n;
    logic [1:0]                    term_wait;
    logic                          term_done;
    logic                          term_high;
  } ddrsp_state_t;

  logic              rst_meta_r;
  logic              rst_sync_r;
  ddrsp_state_t      st_r;
  ddrsp_state_t      st_nxt;
  ddrsp_pins_t       pins_raw;
  logic              k_rise;
  logic              k_n_rise;
  logic              load_read;
  logic              load_write;
  logic [1:0]        bank_wr_en;
  logic [ADDR_W-1:0] bank_wr_addr [0:1];
  logic [WORD_W-1:0] bank_rd_data [0:1];

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_comb begin
    pins_raw.k                        = k_clk_in;
    pins_raw.k_n                      = k_clk_n_in;
    pins_raw.load_strobe_n            = load_strobe_n_in;
    pins_raw.read_not_write           = read_not_write_in;
    pins_raw.addr                     = addr_in;
    pins_raw.byte_lane_write_n        = byte_lane_write_n_in;
    pins_raw.dq                       = dq_in;
    pins_raw.pll_bypass_n             = pll_bypass_n_in;
    pins_raw.termination_range_select = termination_range_select_in;
  end

  // Only the second sync stage feeds edge detection and the access logic
  assign k_rise     = st_r.sync.k && !st_r.k_d;
  assign k_n_rise   = st_r.sync.k_n && !st_r.k_n_d;
  assign load_read  = k_rise && !st_r.sync.load_strobe_n
                      && st_r.sync.read_not_write;
  assign load_write = k_rise && !st_r.sync.load_strobe_n
                      && !st_r.sync.read_not_write;

  // First word goes to bank 0 with the load edge, second to bank 1 on the negative edge
  assign bank_wr_en[0]   = load_write;
  assign bank_wr_addr[0] = st_r.sync.addr;
  assign bank_wr_en[1]   = k_n_rise && st_r.wr_pend;
  assign bank_wr_addr[1] = st_r.wr_addr;

  generate
    for (genvar b = 0; b < BURST_WORDS; b++) begin : g_bank
      ddrsp_bank u_bank (
        .clk_in      (sys_clk_in),
        .wr_en_in    (bank_wr_en[b]),
        .wr_addr_in  (bank_wr_addr[b]),
        .wr_data_in  (st_r.sync.dq),
        .lane_en_in  (~st_r.sync.byte_lane_write_n),
        .rd_addr_in  (st_r.pipe[0].addr),
        .rd_data_out (bank_rd_data[b])
      );
    end
  endgenerate

  always_comb begin
    st_nxt       = st_r;
    st_nxt.meta  = pins_raw;
    st_nxt.sync  = st_r.meta;
    st_nxt.k_d   = st_r.sync.k;
    st_nxt.k_n_d = st_r.sync.k_n;

    // Echo pair retimed like the data path so both move on the same cycle
    st_nxt.echo   = st_r.sync.k;
    st_nxt.echo_n = !st_r.sync.k;

    // Second write word is owed even if the next edge brings no load
    if (load_write) begin
      st_nxt.wr_pend = 1'b1;
      st_nxt.wr_addr = st_r.sync.addr;
    end else if (k_n_rise) begin
      st_nxt.wr_pend = 1'b0;
    end

    // Half-cycle delay line; entries at the head are driven on this edge
    if (k_rise || k_n_rise) begin
      st_nxt.valid = st_r.pipe[0].vld;
      st_nxt.dq_oe = st_r.pipe[0].vld;
      if (st_r.pipe[0].vld) begin
        st_nxt.dq = st_r.pipe[0].word_sel ? bank_rd_data[1] : bank_rd_data[0];
      end else begin
        st_nxt.dq = '0;
      end
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        if (i < PIPE_DEPTH - 1) begin
          st_nxt.pipe[i] = st_r.pipe[i+1];
        end else begin
          st_nxt.pipe[i] = '0;
        end
      end
      if (load_read) begin
        if (st_r.sync.pll_bypass_n) begin
          st_nxt.pipe[LAT_HALF_PLL-1] =
            '{vld: 1'b1, word_sel: 1'b0, addr: st_r.sync.addr};
          st_nxt.pipe[LAT_HALF_PLL] =
            '{vld: 1'b1, word_sel: 1'b1, addr: st_r.sync.addr};
        end else begin
          st_nxt.pipe[LAT_HALF_BYPASS-1] =
            '{vld: 1'b1, word_sel: 1'b0, addr: st_r.sync.addr};
          st_nxt.pipe[LAT_HALF_BYPASS] =
            '{vld: 1'b1, word_sel: 1'b1, addr: st_r.sync.addr};
        end
      end
    end

    // Range pin taken once, after the sync chain has filled
    if (!st_r.term_done) begin
      if (st_r.term_wait == TERM_SETTLE) begin
        st_nxt.term_done = 1'b1;
        st_nxt.term_high = st_r.sync.termination_range_select;
      end else begin
        st_nxt.term_wait = st_r.term_wait + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      st_r           <= '0;
      st_r.term_high <= TERM_HIGH_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dq_out                     = st_r.dq;
  assign dq_oe_out                  = st_r.dq_oe;
  assign output_valid_flag_out      = st_r.valid;
  assign echo_ref_out               = st_r.echo;
  assign echo_ref_n_out             = st_r.echo_n;
  assign termination_high_range_out = st_r.term_high;
endmodule : ddrsp_port

/* File: ddrsp_port_assertions.sv */
`timescale 1ns/100ps
module ddrsp_port_checker (
  input wire logic                         sys_clk_in,
  input wire logic                         reset_n_in,
  input wire logic                         k_clk_in,
  input wire logic [ddrsp_pkg::WORD_W-1:0] dq_out,
  input wire logic                         dq_oe_out,
  input wire logic                         output_valid_flag_out,
  input wire logic                         echo_ref_out,
  input wire logic                         echo_ref_n_out,
  input wire logic                         termination_high_range_out
);
  import ddrsp_pkg::*;
  logic [3:0] settle_r;
  // Echo pair and range only settle some cycles after release
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) settle_r <= 4'h0;
    else if (settle_r != 4'hf) settle_r <= settle_r + 4'h1;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  oe_tracks_valid_a:
    assert property (dq_oe_out == output_valid_flag_out) else $error("oe and valid differ");
  idle_bus_zero_a:
    assert property (!dq_oe_out |-> dq_out == '0) else $error("dq driven while idle");
  echo_pair_a:
    assert property (settle_r == 4'hf |-> echo_ref_n_out != echo_ref_out)
    else $error("echo pair not complementary");
  echo_follow_a:
    assert property (settle_r == 4'hf && $rose(k_clk_in) |-> ##[1:4] $rose(echo_ref_out))
    else $error("echo missed a K rise");
  valid_on_echo_a:
    assert property ($changed(output_valid_flag_out) |-> $changed(echo_ref_out))
    else $error("valid moved off echo");
  data_on_echo_a:
    assert property ($changed(dq_out) |-> $changed(echo_ref_out)) else $error("dq moved off echo");
  range_reset_a:
    assert property ($rose(reset_n_in) |-> termination_high_range_out)
    else $error("range not high in reset");
  range_held_a:
    assert property (settle_r == 4'hf |-> $stable(termination_high_range_out))
    else $error("range changed after capture");
endmodule : ddrsp_port_checker

bind ddrsp_port ddrsp_port_checker chk_u (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .k_clk_in(k_clk_in), .dq_out(dq_out),
  .dq_oe_out(dq_oe_out), .output_valid_flag_out(output_valid_flag_out),
  .echo_ref_out(echo_ref_out), .echo_ref_n_out(echo_ref_n_out),
  .termination_high_range_out(termination_high_range_out));

/* File: ddrsp_ctrl_model.sv */
`timescale 1ns/100ps
module ddrsp_ctrl_model (
  input  wire logic [ddrsp_pkg::WORD_W-1:0] dq_dev_in,
  input  wire logic                         dq_oe_in,
  output logic                              k_clk_out,
  output logic                              k_clk_n_out,
  output logic                              load_strobe_n_out,
  output logic                              read_not_write_out,
  output logic      [ddrsp_pkg::ADDR_W-1:0] addr_out,
  output logic      [ddrsp_pkg::LANES-1:0]  byte_lane_write_n_out,
  output logic                              pll_bypass_n_out,
  output logic      [ddrsp_pkg::WORD_W-1:0] dq_bus_out
);
  import ddrsp_pkg::*;
  logic              drive_r = 1'b0;
  logic [WORD_W-1:0] wdata_r = '0;
  logic [WORD_W-1:0] float_r = 18'h2aaaa;
  initial begin
    {load_strobe_n_out, read_not_write_out, addr_out} = {2'b10, 20'h0};
    {byte_lane_write_n_out, pll_bypass_n_out} = 3'h7;
    k_clk_out = 1'b0;
    // Offset keeps K edges clear of system clock edges
    #10;
    forever begin
      k_clk_out = ~k_clk_out;
      #160;
    end
  end
  assign k_clk_n_out = ~k_clk_out;
  // Released bus never shows a stale value
  always @(k_clk_out) float_r <= ~float_r;
  assign dq_bus_out = dq_oe_in ? dq_dev_in : (drive_r ? wdata_r : float_r);
  // One K cycle slot, entered 80 ns before a K rise
  task automatic slot(input logic ld_n, rnw, input logic [ADDR_W-1:0] a,
                      input logic [WORD_W-1:0] w0, w1, input logic [LANES-1:0] b0, b1,
                      input logic byp_n);
    load_strobe_n_out = ld_n;
    read_not_write_out = rnw;
    addr_out = a;
    pll_bypass_n_out = byp_n;
    drive_r = !ld_n && !rnw;
    wdata_r = w0;
    byte_lane_write_n_out = b0;
    @(posedge k_clk_out);
    #80;
    wdata_r = w1;
    byte_lane_write_n_out = b1;
    @(posedge k_clk_n_out);
    #80;
  endtask : slot
endmodule : ddrsp_ctrl_model

/* File: ddrsp_port_bench.sv */
`timescale 1ns/100ps
module ddrsp_port_bench;
  import ddrsp_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, term_sel = 1'b0, started = 1'b0, echo_prev;
  logic k_clk, k_clk_n, ld_n, rnw, byp_n, dq_oe, valid, echo_ref, echo_n, term_hi;
  logic [ADDR_W-1:0] addr, addrs [4];
  logic [LANES-1:0] bws_n;
  logic [WORD_W-1:0] dq_bus, dq_out, exp_d [int];
  logic [2*WORD_W-1:0] mem [int];
  logic [31:0] lfsr_r = 32'h6;
  int fails = 0, tests_run = 0, hk = 0;
  initial forever #20 sys_clk = ~sys_clk;
  ddrsp_ctrl_model ctrl_u (.dq_dev_in(dq_out), .dq_oe_in(dq_oe), .k_clk_out(k_clk),
    .k_clk_n_out(k_clk_n), .load_strobe_n_out(ld_n), .read_not_write_out(rnw), .addr_out(addr),
    .byte_lane_write_n_out(bws_n), .pll_bypass_n_out(byp_n), .dq_bus_out(dq_bus));
  ddrsp_port dut_u (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .k_clk_in(k_clk),
    .k_clk_n_in(k_clk_n), .load_strobe_n_in(ld_n), .read_not_write_in(rnw), .addr_in(addr),
    .byte_lane_write_n_in(bws_n), .dq_in(dq_bus), .pll_bypass_n_in(byp_n),
    .termination_range_select_in(term_sel), .dq_out(dq_out), .dq_oe_out(dq_oe),
    .output_valid_flag_out(valid), .echo_ref_out(echo_ref), .echo_ref_n_out(echo_n),
    .termination_high_range_out(term_hi));
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 8; i++) lfsr_r = {lfsr_r[30:0], ^(lfsr_r & 32'h80200003)};
    return lfsr_r;
  endfunction : rnd
  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o, n,
                                               input logic [LANES-1:0] b);
    return {b[1] ? o[17:9] : n[17:9], b[0] ? o[8:0] : n[8:0]};
  endfunction : merge
  task automatic check(input logic [WORD_W-1:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic do_reset(input logic sel);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    term_sel <= sel;
    repeat (5) @(posedge sys_clk);
    check(WORD_W'(term_hi), WORD_W'(1'b1));
    reset_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
    check(WORD_W'(term_hi), WORD_W'(sel));
    term_sel <= ~sel;
  endtask : do_reset
  task automatic idle(input int n);
    repeat (n) ctrl_u.slot(1'b1, 1'b0, '0, '0, '0, 2'h3, 2'h3, 1'b1);
  endtask : idle
  task automatic op(input logic rd, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] b0, b1,
                    input logic bp);
    logic [WORD_W-1:0] w0, w1;
    int h;
    w0 = WORD_W'(rnd());
    w1 = WORD_W'(rnd());
    ctrl_u.slot(1'b0, rd, a, w0, w1, b0, b1, bp);
    h = hk - 1 + (bp ? LAT_HALF_PLL : LAT_HALF_BYPASS);
    if (!mem.exists(a)) mem[a] = 'x;
    if (rd) begin
      exp_d[h] = mem[a][WORD_W-1:0];
      exp_d[h+1] = mem[a][2*WORD_W-1:WORD_W];
    end else begin
      mem[a] = {merge(mem[a][2*WORD_W-1:WORD_W], w1, b1),
                merge(mem[a][WORD_W-1:0], w0, b0)};
    end
  endtask : op
  always @(k_clk) hk <= hk + 1;
  always @(negedge sys_clk) begin
    echo_prev <= echo_ref;
    if (started && echo_ref !== echo_prev) begin
      check(WORD_W'(valid), WORD_W'(exp_d.exists(hk)));
      check(dq_out, exp_d.exists(hk) ? exp_d[hk] : '0);
    end
  end
  initial begin
    #200000;
    fails++;
    final_report();
  end
  initial begin
    logic rd, last;
    do_reset(1'b0);
    do_reset(1'b1);
    started = 1'b1;
    addrs = '{20'h0, 20'hfffff, ADDR_W'(rnd()), ADDR_W'(rnd())};
    @(posedge k_clk_n);
    #80;
    for (int m = 0; m < 4; m++) begin
      // Even passes write every lane of both words so no read expects an unknown
      for (int i = 0; i < 4; i++) begin
        op(1'b0, addrs[i], m[0] ? 2'(rnd()) : 2'h0,
           (2'(rnd()) | {2{!m[0]}}) ^ 2'h3, 1'b1);
      end
      for (int i = 0; i < 4; i++) op(1'b1, addrs[i], 2'h3, 2'h3, m < 2);
      idle(3);
    end
    last = 1'b0;
    for (int i = 0; i < 24; i++) begin
      rd = rnd() % 2;
      if (rd != last) idle(3);
      op(rd, addrs[rnd() % 4], 2'(rnd()), 2'(rnd()), 1'b1);
      last = rd;
    end
    idle(4);
    final_report();
  end
endmodule : ddrsp_port_bench
